// ---- rtl/ppc_port.sv ----
// Notes on behaviour
// RQ1: reset leaves pins analog high impedance
// RQ2: analog mode gives no digital input
// RQ3: digital high-Z: driver off, input on
// RQ4: pull-up/down: resistive one side, strong other
// RQ5: regulated special pin blocks resistive modes
// RQ6: open drain drives one level, floats other
// RQ7: strong mode drives both levels
// RQ8: combined resistive mode never strong
// RQ9: port and pin forms share storage
// RQ10: bidir switches between input and drive
// RQ11: sixteen output enables routable to pins
// RQ12: edge rate only for strong/open drain
// RQ13: software picks slow below one megahertz
// RQ14: one interrupt unit for eight pins
// RQ15: per pin rise, fall, both, none
// RQ16: edge sets status bit and request
// RQ17: edge detection works in sleep
// RQ18: no level sensitive interrupts
// RQ19: port threshold select, per pin input disable
// RQ20: special pin regulated high output select
// RQ21: pin pair shares threshold reference
// RQ22: analog reference and hysteresis options
// RQ23: three-bit drive code selects mode
// RQ24: output data from register or bypass
// RQ25: pin level readback separate from data
// RQ26: synchronised inputs; status clears on read
// RQ27: bidir disable forces driver off
`timescale 1ns/1ps
`default_nettype none
module ppc_port
    import ppc_pkg::*;
#(
    parameter int unsigned NP = ppc_pkg::NPINS
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NP-1:0]        pin_in,
    input  wire logic [NP-1:0]        sys_out,
    input  wire logic [15:0]          aux_oe,
    output logic      [NP-1:0]        pin_drive_high,
    output logic      [NP-1:0]        pin_drive_low,
    output logic      [NP-1:0]        pin_pull_up,
    output logic      [NP-1:0]        pin_pull_down,
    output logic      [NP-1:0]        pin_inbuf_en,
    output logic      [NP-1:0]        edge_rate_select,
    output logic                      lvttl_sel,
    output logic      [1:0]           regulated_out,
    output logic      [1:0]           ref_thresh_sel,
    output logic                      ref_analog_sel,
    output logic                      hyst_en,
    output logic      [NP-1:0]        sys_in,
    output logic                      port_irq
);
    import ppc_pkg::*;

    typedef struct packed {
        logic [NP-1:0]        dm0;
        logic [NP-1:0]        dm1;
        logic [NP-1:0]        dm2;
        logic [NP-1:0]        data;
        logic [NP-1:0]        byp;
        logic [NP-1:0]        slow;
        logic [NP-1:0]        indis;
        logic [NP-1:0]        bidir;
        logic                 lvttl;
        logic [5:0]           spf;
        logic [2*NP-1:0]      inttype;
        logic [NP-1:0]        stat;
        logic [4*NP-1:0]      oesel;
        logic [NP-1:0]        sync1;
        logic [NP-1:0]        sync2;
        logic [NP-1:0]        prev;
        logic [31:0]          rdata;
    } ppc_state_t;

    ppc_state_t st_q;
    ppc_state_t st_d;

    logic          acc;
    logic          wr;
    logic          rd;
    logic [NP-1:0] oe_ok;
    logic [NP-1:0] out_val;
    logic [NP-1:0] evt;
    logic [NP-1:0] in_en;
    logic [NP-1:0] dh;
    logic [NP-1:0] dl;
    logic [NP-1:0] pu;
    logic [NP-1:0] pd;
    logic          mapped;
    logic          rd_setup;
    logic [31:0]   rd_mux;

    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rd_mux = RST_VAL;
        if (paddr == OFS_DM0) begin
            rd_mux[NP-1:0] = st_q.dm0;
        end else if (paddr == OFS_DM1) begin
            rd_mux[NP-1:0] = st_q.dm1;
        end else if (paddr == OFS_DM2) begin
            rd_mux[NP-1:0] = st_q.dm2;
        end else if (paddr == OFS_DATA) begin
            rd_mux[NP-1:0] = st_q.data;
        end else if (paddr == OFS_LEVEL) begin
            rd_mux[NP-1:0] = st_q.sync2 & in_en; // RQ25 RQ2
        end else if (paddr == OFS_BYP) begin
            rd_mux[NP-1:0] = st_q.byp;
        end else if (paddr == OFS_SLOW) begin
            rd_mux[NP-1:0] = st_q.slow;
        end else if (paddr == OFS_INDIS) begin
            rd_mux[NP-1:0] = st_q.indis;
        end else if (paddr == OFS_BIDIR) begin
            rd_mux[NP-1:0] = st_q.bidir;
        end else if (paddr == OFS_CTL) begin
            rd_mux[CTL_LVTTL] = st_q.lvttl;
        end else if (paddr == OFS_INTTYPE) begin
            rd_mux[2*NP-1:0] = st_q.inttype;
        end else if (paddr == OFS_INTSTAT) begin
            // an event landing in the setup cycle is reported before the clear
            rd_mux[NP-1:0] = st_q.stat | evt; // RQ16
        end else if (paddr == OFS_OESEL_LO) begin
            rd_mux = st_q.oesel[31:0];
        end else if (paddr == OFS_SPF) begin
            rd_mux[5:0] = st_q.spf;
        end else if (paddr >= OFS_PIN0 && paddr <= OFS_PIN7 && paddr[1:0] == 2'b00) begin
            for (int i = 0; i < NP; i++) begin
                if (paddr[4:2] == i[2:0]) begin
                    rd_mux[PF_DATA]  = st_q.data[i]; // RQ9
                    rd_mux[PF_DM_LO] = st_q.dm0[i];
                    rd_mux[PF_DM_LO+1] = st_q.dm1[i];
                    rd_mux[PF_DM_HI] = st_q.dm2[i];
                    rd_mux[PF_SLOW]  = st_q.slow[i];
                    rd_mux[PF_BYP]   = st_q.byp[i];
                    rd_mux[PF_BIDIR] = st_q.bidir[i];
                    rd_mux[PF_INDIS] = st_q.indis[i];
                end
            end
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = acc && !mapped;
    assign prdata  = st_q.rdata;

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pin
            logic [2:0] code;
            logic       v;
            logic       regm;
            assign code = {st_q.dm2[g], st_q.dm1[g], st_q.dm0[g]}; // RQ23
            assign oe_ok[g] = !st_q.bidir[g] || aux_oe[st_q.oesel[4*g +: 4]]; // RQ10 RQ11
            assign out_val[g] = st_q.byp[g] ? sys_out[g] : st_q.data[g]; // RQ24
            assign v = out_val[g];
            if (g < 2) begin : g_spf
                assign regm = st_q.spf[g]; // RQ20
            end else begin : g_std
                assign regm = 1'b0;
            end
            always_comb begin
                dh[g] = 1'b0;
                dl[g] = 1'b0;
                pu[g] = 1'b0;
                pd[g] = 1'b0;
                case (code)
                    PPC_DM_PULL_UP: begin // RQ4
                        pu[g] = v && !regm; // RQ5
                        dl[g] = !v;
                    end
                    PPC_DM_PULL_DOWN: begin
                        dh[g] = v;
                        pd[g] = !v && !regm; // RQ5
                    end
                    PPC_DM_OD_LOW: dl[g] = !v; // RQ6
                    PPC_DM_OD_HIGH: dh[g] = v;
                    PPC_DM_STRONG: begin // RQ7
                        dh[g] = v;
                        dl[g] = !v;
                    end
                    PPC_DM_PULL_BOTH: begin // RQ8
                        pu[g] = v && !regm;
                        pd[g] = !v && !regm;
                    end
                    default: ; // RQ1 RQ3
                endcase
            end
            assign in_en[g] = code != PPC_DM_HIZ_ANALOG && !st_q.indis[g]; // RQ2 RQ19
            assign pin_drive_high[g] = dh[g] && oe_ok[g]; // RQ27
            assign pin_drive_low[g]  = dl[g] && oe_ok[g];
            assign pin_pull_up[g]    = pu[g] && oe_ok[g];
            assign pin_pull_down[g]  = pd[g] && oe_ok[g];
            assign edge_rate_select[g] = st_q.slow[g] && (code == PPC_DM_OD_LOW
                || code == PPC_DM_OD_HIGH || code == PPC_DM_STRONG); // RQ12
            always_comb begin
                case (st_q.inttype[2*g +: 2]) // RQ15 RQ18
                    PPC_INT_RISE: evt[g] = st_q.sync2[g] && !st_q.prev[g];
                    PPC_INT_FALL: evt[g] = !st_q.sync2[g] && st_q.prev[g];
                    PPC_INT_BOTH: evt[g] = st_q.sync2[g] != st_q.prev[g];
                    default:      evt[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign pin_inbuf_en   = in_en;
    assign sys_in         = st_q.sync2 & in_en;
    assign lvttl_sel      = st_q.lvttl;
    assign regulated_out  = st_q.spf[SPF_REG1:SPF_REG0];
    assign ref_thresh_sel = st_q.spf[SPF_THR_HI:SPF_THR_LO]; // RQ21
    assign ref_analog_sel = st_q.spf[SPF_AREF]; // RQ22
    assign hyst_en        = st_q.spf[SPF_HYST];
    assign port_irq       = |st_q.stat; // RQ14 RQ16

    always_comb begin
        st_d = st_q;
        st_d.sync1 = pin_in; // RQ26
        st_d.sync2 = st_q.sync1;
        st_d.prev  = st_q.sync2; // RQ17
        // read data is taken in the setup cycle so it stands during the access phase
        if (rd_setup) begin
            st_d.rdata = rd_mux; // RQ25
        end
        if (rd && paddr == OFS_INTSTAT) begin
            st_d.stat = '0; // RQ26
        end
        if (wr) begin
            if (paddr == OFS_DM0) begin
                st_d.dm0 = pwdata[NP-1:0];
            end else if (paddr == OFS_DM1) begin
                st_d.dm1 = pwdata[NP-1:0];
            end else if (paddr == OFS_DM2) begin
                st_d.dm2 = pwdata[NP-1:0];
            end else if (paddr == OFS_DATA) begin
                st_d.data = pwdata[NP-1:0];
            end else if (paddr == OFS_BYP) begin
                st_d.byp = pwdata[NP-1:0];
            end else if (paddr == OFS_SLOW) begin
                st_d.slow = pwdata[NP-1:0];
            end else if (paddr == OFS_INDIS) begin
                st_d.indis = pwdata[NP-1:0];
            end else if (paddr == OFS_BIDIR) begin
                st_d.bidir = pwdata[NP-1:0];
            end else if (paddr == OFS_CTL) begin
                st_d.lvttl = pwdata[CTL_LVTTL];
            end else if (paddr == OFS_INTTYPE) begin
                st_d.inttype = pwdata[2*NP-1:0];
            end else if (paddr == OFS_OESEL_LO) begin
                st_d.oesel = pwdata[4*NP-1:0];
            end else if (paddr == OFS_SPF) begin
                st_d.spf = pwdata[5:0];
            end else if (paddr >= OFS_PIN0 && paddr <= OFS_PIN7 && paddr[1:0] == 2'b00) begin
                for (int i = 0; i < NP; i++) begin
                    if (paddr[4:2] == i[2:0]) begin
                        st_d.data[i]  = pwdata[PF_DATA]; // RQ9
                        st_d.dm0[i]   = pwdata[PF_DM_LO];
                        st_d.dm1[i]   = pwdata[PF_DM_LO+1];
                        st_d.dm2[i]   = pwdata[PF_DM_HI];
                        st_d.slow[i]  = pwdata[PF_SLOW];
                        st_d.byp[i]   = pwdata[PF_BYP];
                        st_d.bidir[i] = pwdata[PF_BIDIR];
                        st_d.indis[i] = pwdata[PF_INDIS];
                    end
                end
            end
        end
        // new events win over the read clear
        st_d.stat = st_d.stat | evt; // RQ16
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0; // RQ1
        end else begin
            st_q <= st_d;
        end
    end

    chk_edge_sets_stat: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        (evt != '0) |=> ((st_q.stat & $past(evt)) == $past(evt)) && port_irq)
        else $error("edge did not set status");
    chk_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // RQ26
        (rd && paddr == OFS_INTSTAT && evt == '0) |=> st_q.stat == '0)
        else $error("status not cleared by read");
    chk_analog_no_in: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (g_pin[0].code == PPC_DM_HIZ_ANALOG) |-> !sys_in[0] && !pin_inbuf_en[0])
        else $error("analog pin shows input");
    chk_bidir_off: assert property (@(posedge pclk) disable iff (!presetn) // RQ27
        !oe_ok[5] |-> !(pin_drive_high[5] || pin_drive_low[5] || pin_pull_up[5]
        || pin_pull_down[5]))
        else $error("driver on while oe low");
    chk_strong_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (g_pin[2].code == PPC_DM_STRONG && oe_ok[2]) |-> pin_drive_high[2] == out_val[2]
        && pin_drive_low[2] == !out_val[2])
        else $error("strong drive mismatch");
    chk_pull_both: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (g_pin[0].code == PPC_DM_PULL_BOTH) |-> !pin_drive_high[0] && !pin_drive_low[0])
        else $error("pull mode drives strongly");
    chk_regulated_pull: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        st_q.spf[SPF_REG0] |-> !pin_pull_up[0] && !pin_pull_down[0])
        else $error("pull active in regulated mode");
    chk_slew_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        edge_rate_select[2] |-> g_pin[2].code[2] && g_pin[2].code != PPC_DM_PULL_BOTH)
        else $error("slew on resistive mode");
    chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn) // RQ26
        $rose(pin_in[0]) |-> ##2 st_q.sync2[0])
        else $error("sync delay wrong");
    chk_od_low: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (g_pin[2].code == PPC_DM_OD_LOW && oe_ok[2]) |-> !pin_drive_high[2]
        && pin_drive_low[2] == !out_val[2])
        else $error("open drain low drove high");

    chk_reset_hiz: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        (st_q.dm0 == '0 && st_q.dm1 == '0 && st_q.dm2 == '0) |-> pin_inbuf_en == '0
        && (pin_drive_high | pin_drive_low | pin_pull_up | pin_pull_down) == '0)
        else $error("analog state not high impedance");
    chk_digital_hiz: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (g_pin[2].code == PPC_DM_HIZ_DIGITAL) |-> pin_inbuf_en[2] == !st_q.indis[2]
        && !(pin_drive_high[2] || pin_drive_low[2] || pin_pull_up[2] || pin_pull_down[2]))
        else $error("digital high impedance pin drives");
    chk_pull_up_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (g_pin[2].code == PPC_DM_PULL_UP && oe_ok[2]) |-> pin_pull_up[2] == out_val[2]
        && pin_drive_low[2] == !out_val[2] && !pin_drive_high[2])
        else $error("pull-up mode drive wrong");
    chk_pull_down_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (g_pin[2].code == PPC_DM_PULL_DOWN && oe_ok[2]) |-> pin_drive_high[2] == out_val[2]
        && pin_pull_down[2] == !out_val[2] && !pin_drive_low[2])
        else $error("pull-down mode drive wrong");
    chk_od_high: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (g_pin[2].code == PPC_DM_OD_HIGH && oe_ok[2]) |-> !pin_drive_low[2]
        && pin_drive_high[2] == out_val[2])
        else $error("open drain high drove low");
    chk_pin_form_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        (rd_setup && paddr == OFS_PIN0 + 12'h008) |=> prdata[PF_DATA] == $past(st_q.data[2])
        && prdata[PF_DM_HI:PF_DM_LO] == $past(g_pin[2].code))
        else $error("pin form read differs from port form");
    chk_bidir_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        (st_q.bidir[5] && g_pin[5].code == PPC_DM_STRONG && aux_oe[st_q.oesel[20 +: 4]])
        |-> pin_drive_high[5] == out_val[5] && pin_drive_low[5] == !out_val[5])
        else $error("bidir pin not driving when enabled");
    chk_rise_event: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        (st_q.inttype[13:12] == PPC_INT_RISE && st_q.sync2[6] && !st_q.prev[6])
        |=> st_q.stat[6])
        else $error("rising edge not flagged");
    chk_fall_event: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        (st_q.inttype[13:12] == PPC_INT_FALL && !st_q.sync2[6] && st_q.prev[6])
        |=> st_q.stat[6])
        else $error("falling edge not flagged");
    chk_no_event: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        (st_q.inttype[13:12] == PPC_INT_NONE) |-> !evt[6])
        else $error("event with detection off");
    chk_no_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
        (st_q.sync2[6] == st_q.prev[6]) |-> !evt[6])
        else $error("steady level raised an event");
    chk_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        (st_q.stat[6] && !(rd && paddr == OFS_INTSTAT)) |=> st_q.stat[6])
        else $error("status bit lost without read");
    chk_in_disable: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
        st_q.indis[3] |-> !pin_inbuf_en[3] && !sys_in[3])
        else $error("disabled input buffer active");
    chk_bypass_data: assert property (@(posedge pclk) disable iff (!presetn) // RQ24
        (st_q.byp[4] && g_pin[4].code == PPC_DM_STRONG && oe_ok[4])
        |-> pin_drive_high[4] == sys_out[4] && pin_drive_low[4] == !sys_out[4])
        else $error("bypass data not driven");
    chk_level_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ25
        (rd_setup && paddr == OFS_LEVEL) |=> prdata[NP-1:0] == $past(st_q.sync2 & pin_inbuf_en))
        else $error("pin level readback wrong");
endmodule : ppc_port
`default_nettype wire

// ---- rtl/ppc_pkg.sv ----
package ppc_pkg;
    localparam int unsigned NPINS = 8;
    localparam int unsigned NOE = 16;
    localparam int unsigned OE_SEL_W = 4;
    // register byte offsets
    localparam logic [11:0] OFS_DM0 = 12'h000;
    localparam logic [11:0] OFS_DM1 = 12'h004;
    localparam logic [11:0] OFS_DM2 = 12'h008;
    localparam logic [11:0] OFS_DATA = 12'h00c;
    localparam logic [11:0] OFS_LEVEL = 12'h010;
    localparam logic [11:0] OFS_BYP = 12'h014;
    localparam logic [11:0] OFS_SLOW = 12'h018;
    localparam logic [11:0] OFS_INDIS = 12'h01c;
    localparam logic [11:0] OFS_BIDIR = 12'h020;
    localparam logic [11:0] OFS_CTL = 12'h024;
    localparam logic [11:0] OFS_INTTYPE = 12'h028;
    localparam logic [11:0] OFS_INTSTAT = 12'h02c;
    localparam logic [11:0] OFS_OESEL_LO = 12'h030;
    localparam logic [11:0] OFS_OESEL_HI = 12'h034;
    localparam logic [11:0] OFS_SPF = 12'h038;
    localparam logic [11:0] OFS_PIN0 = 12'h040;
    localparam logic [11:0] OFS_PIN7 = 12'h05c;
    // per-pin form field positions
    localparam int unsigned PF_DATA = 0;
    localparam int unsigned PF_DM_LO = 1;
    localparam int unsigned PF_DM_HI = 3;
    localparam int unsigned PF_SLOW = 4;
    localparam int unsigned PF_BYP = 5;
    localparam int unsigned PF_BIDIR = 6;
    localparam int unsigned PF_INDIS = 7;
    // port control fields
    localparam int unsigned CTL_LVTTL = 0;
    // special pin fields: 0 regulated pin0, 1 regulated pin1, 3:2 threshold, 4 analog ref, 5 hyst
    localparam int unsigned SPF_REG0 = 0;
    localparam int unsigned SPF_REG1 = 1;
    localparam int unsigned SPF_THR_LO = 2;
    localparam int unsigned SPF_THR_HI = 3;
    localparam int unsigned SPF_AREF = 4;
    localparam int unsigned SPF_HYST = 5;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    typedef enum logic [2:0] {
        PPC_DM_HIZ_ANALOG = 3'h0,
        PPC_DM_HIZ_DIGITAL = 3'h1,
        PPC_DM_PULL_UP = 3'h2,
        PPC_DM_PULL_DOWN = 3'h3,
        PPC_DM_OD_LOW = 3'h4,
        PPC_DM_OD_HIGH = 3'h5,
        PPC_DM_STRONG = 3'h6,
        PPC_DM_PULL_BOTH = 3'h7
    } ppc_dm_t;
    typedef enum logic [1:0] {
        PPC_INT_NONE = 2'h0,
        PPC_INT_RISE = 2'h1,
        PPC_INT_FALL = 2'h2,
        PPC_INT_BOTH = 2'h3
    } ppc_int_t;
endpackage : ppc_pkg

// ---- dv/ppc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [ppc_pkg::NPINS-1:0]  drv_hi,
    input  wire logic [ppc_pkg::NPINS-1:0]  drv_lo,
    input  wire logic [ppc_pkg::NPINS-1:0]  pu,
    input  wire logic [ppc_pkg::NPINS-1:0]  pd,
    input  wire logic [ppc_pkg::NPINS-1:0]  ext_en,
    input  wire logic [ppc_pkg::NPINS-1:0]  ext_val,
    output logic      [ppc_pkg::NPINS-1:0]  pin_level
);
    import ppc_pkg::*;
    logic [NPINS-1:0] float_q;
    // an undriven pin wanders: pattern flips every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            float_q <= 8'h55;
        end else begin
            float_q <= ~float_q;
        end
    end
    // strong drive wins, then the external source, then the resistors
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (drv_hi[i]) pin_level[i] = 1'b1;
            else if (drv_lo[i]) pin_level[i] = 1'b0;
            else if (ext_en[i]) pin_level[i] = ext_val[i];
            else if (pu[i]) pin_level[i] = 1'b1;
            else if (pd[i]) pin_level[i] = 1'b0;
            else pin_level[i] = float_q[i];
        end
    end
endmodule : ppc_pin_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import ppc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        lvttl, aref, hyst, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  ext_en, ext_val, sys_out, drv_hi, drv_lo, pu, pd, inbuf, slow, sys_in, level;
    logic [15:0] aux_oe;
    logic [1:0]  reg_out, thr;
    int          num_errors, checks_done;
    int          rm[3] = '{2, 3, 7};
    logic [15:0] av[3] = '{16'h0000, 16'h0800, 16'hf7ff};
    logic [2:0]  ex[3] = '{3'h1, 3'h5, 3'h1};

    ppc_port #(.NP(NPINS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(level), .sys_out(sys_out), .aux_oe(aux_oe), .pin_drive_high(drv_hi),
        .pin_drive_low(drv_lo), .pin_pull_up(pu), .pin_pull_down(pd), .pin_inbuf_en(inbuf),
        .edge_rate_select(slow), .lvttl_sel(lvttl), .regulated_out(reg_out),
        .ref_thresh_sel(thr), .ref_analog_sel(aref), .hyst_en(hyst), .sys_in(sys_in),
        .port_irq(irq));
    ppc_pin_model model (
        .pclk(pclk), .presetn(presetn), .drv_hi(drv_hi), .drv_lo(drv_lo), .pu(pu), .pd(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pin_level(level));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        // let the access edge settle before callers compare outputs
        @(negedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e);
    endtask : rdchk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : wt
    function automatic logic [4:0] drv(input int n);
        return {drv_hi[n], drv_lo[n], pu[n], pd[n], inbuf[n]};
    endfunction : drv
    // {high, low, pull up, pull down, input on} per code and data
    function automatic logic [4:0] exp_drv(input logic [2:0] m, input logic d);
        case (m)
            3'h0: return 5'h00;
            3'h1: return 5'h01;
            3'h2: return d ? 5'h05 : 5'h09;
            3'h3: return d ? 5'h11 : 5'h03;
            3'h4: return d ? 5'h01 : 5'h09;
            3'h5: return d ? 5'h11 : 5'h01;
            3'h6: return d ? 5'h11 : 5'h09;
            default: return d ? 5'h05 : 5'h03;
        endcase
    endfunction : exp_drv
    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        #1_000_000;
        num_errors++;
        wrap_up();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; ext_en = 8'hff; ext_val = 8'hff; sys_out = 8'h00;
        aux_oe = 16'h0000; num_errors = 0; checks_done = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wt(3);
        `CHK({drv_hi, drv_lo, pu, pd, inbuf, irq}, 41'h0);
        `CHK(sys_in, 8'h00);
        rdchk(OFS_LEVEL, 32'h0000_0000);
        rdchk(OFS_DM0, RST_VAL);
        @(posedge pclk) ext_en <= 8'h00;
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(OFS_PIN0 + 12'h008, 32'h0000_0010 | 32'(m << 1) | 32'(d));
                `CHK(drv(2), exp_drv(3'(m), d[0]));
                `CHK(slow[2], 1'(m inside {4, 5, 6}));
            end
        end
        wr(OFS_DM0, 32'h0000_0000);
        wr(OFS_DM1, 32'h0000_0004);
        wr(OFS_DM2, 32'h0000_0000);
        wr(OFS_DATA, 32'h0000_0000);
        rdchk(OFS_PIN0 + 12'h008, 32'h0000_0014);
        rdchk(OFS_SLOW, 32'h0000_0004);
        wr(OFS_SPF, 32'h0000_003d);
        `CHK({hyst, aref, thr, reg_out}, 6'h3d);
        foreach (rm[k]) begin
            for (int d = 1; d >= 0; d--) begin
                wr(OFS_PIN0, 32'(rm[k] << 1) | 32'(d));
                `CHK({pu[0], pd[0]}, 2'h0);
            end
        end
        wr(OFS_PIN0 + 12'h004, 32'h0000_0005);
        `CHK(pu[1], 1'b1);
        wr(OFS_PIN0, 32'h0000_0000);
        wr(OFS_PIN0 + 12'h004, 32'h0000_0000);
        wr(OFS_CTL, 32'h0000_0001);
        `CHK(lvttl, 1'b1);
        wr(OFS_PIN0 + 12'h00c, 32'h0000_0002);
        @(posedge pclk) begin
            ext_en <= 8'h08;
            ext_val <= 8'h08;
        end
        wt(4);
        `CHK(sys_in[3], 1'b1);
        rdchk(OFS_LEVEL, 32'h0000_0008);
        rdchk(OFS_DATA, 32'h0000_0000);
        wr(OFS_INDIS, 32'h0000_0008);
        `CHK(inbuf[3], 1'b0);
        rdchk(OFS_LEVEL, 32'h0000_0000);
        wr(OFS_INDIS, 32'h0000_0000);
        wr(OFS_PIN0 + 12'h010, 32'h0000_002c);
        for (int d = 0; d < 2; d++) begin
            @(posedge pclk) sys_out <= 8'(d << 4);
            wt(1);
            `CHK({drv_hi[4], drv_lo[4]}, d ? 2'h2 : 2'h1);
        end
        wr(OFS_OESEL_LO, 32'h00b0_0000);
        wr(OFS_PIN0 + 12'h014, 32'h0000_004d);
        for (int k = 0; k < 3; k++) begin
            @(posedge pclk) aux_oe <= av[k];
            wt(1);
            `CHK({drv_hi[5], drv_lo[5], inbuf[5]}, ex[k]);
        end
        apb(1'b1, OFS_OESEL_HI, 32'hffff_ffff);
        `CHK(err, 1'b1);
        apb(1'b0, OFS_OESEL_HI, 32'h0000_0000);
        `CHK({err, rd}, 33'h1_0000_0000);
        @(posedge pclk) ext_en <= 8'h48;
        wr(OFS_PIN0 + 12'h018, 32'h0000_0002);
        for (int t = 0; t < 4; t++) begin
            wr(OFS_INTTYPE, 32'(t) << 12);
            @(posedge pclk) ext_val <= 8'h48;
            wt(5);
            `CHK(irq, t[0]);
            rdchk(OFS_INTSTAT, 32'(t[0]) << 6);
            wt(5);
            `CHK(irq, 1'b0);
            @(posedge pclk) ext_val <= 8'h08;
            wt(5);
            `CHK(irq, t[1]);
            rdchk(OFS_INTSTAT, 32'(t[1]) << 6);
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
